// ---- fbsm_power_guard.sv ----
// package of shared constants and the power stage interlock module
`timescale 1ns/10ps
package fbsm_pkg;
   // requested and reported state codes, one-hot as the master writes them
   localparam logic [3:0] CODE_INIT = 4'h1;
   localparam logic [3:0] CODE_PREOP = 4'h2;
   localparam logic [3:0] CODE_SAFEOP = 4'h4;
   localparam logic [3:0] CODE_OP = 4'h8;
   localparam logic [3:0] STATUS_RESET = CODE_INIT;
   localparam logic ERROR_RESET = 1'b0;

   // communication states, ordered from lowest to highest
   typedef enum logic [1:0] {
      CS_INIT,
      CS_PREOP,
      CS_SAFEOP,
      CS_OP
   } fbsm_comm_t;

   // power stage states; code 7 is unused and therefore illegal
   typedef enum logic [2:0] {
      PS_NOT_READY,
      PS_SWITCH_ON_DISABLED,
      PS_READY,
      PS_SWITCHED_ON,
      PS_OP_ENABLED,
      PS_FAULT_REACTION,
      PS_FAULT
   } fbsm_power_t;

   // reported code of a communication state
   function automatic logic [3:0] fbsm_code(input fbsm_comm_t s);
      unique case (s)
         CS_INIT: fbsm_code = CODE_INIT;
         CS_PREOP: fbsm_code = CODE_PREOP;
         CS_SAFEOP: fbsm_code = CODE_SAFEOP;
         CS_OP: fbsm_code = CODE_OP;
      endcase
   endfunction : fbsm_code
endpackage : fbsm_pkg

////////////////////////////////////////////////////////////////////////////////
module fbsm_power_guard (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // communication side
   input wire logic cmd_taken,
   input wire logic to_init,
   input wire fbsm_pkg::fbsm_comm_t comm_state,
   // power stage side
   input wire fbsm_pkg::fbsm_power_t power_state,
   output logic power_force_disable,
   output logic power_op_enable_allowed,
   output logic power_combo_illegal
);
   import fbsm_pkg::*;

   typedef struct packed {
      logic force_dis;
      logic allow;
      logic illegal;
   } fbsm_guard_t;

   fbsm_guard_t st;
   fbsm_guard_t next_st;

   // interlock terms, all registered so the power stage sees clean levels
   always_comb begin
      next_st = st;
      // a drop to init, or any command while enabled, shuts the stage off
      next_st.force_dis = to_init
         || (cmd_taken && power_state == PS_OP_ENABLED);
      next_st.allow = (comm_state == CS_OP);
      // disabled and fault states are legal everywhere and never flagged
      next_st.illegal = (power_state == PS_NOT_READY && comm_state != CS_INIT)
         || (comm_state == CS_INIT && (power_state == PS_READY
         || power_state == PS_SWITCHED_ON
         || power_state == PS_OP_ENABLED))
         || (power_state > PS_FAULT);
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign power_force_disable = st.force_dis;
   assign power_op_enable_allowed = st.allow;
   assign power_combo_illegal = st.illegal;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_force_on_init: assert property (to_init |=> power_force_disable)
      else $error("drop to init did not force power disable");
   chk_force_when_enabled: assert property (
      cmd_taken && power_state == PS_OP_ENABLED |=> power_force_disable)
      else $error("command while enabled did not force disable");
   chk_init_combo: assert property (
      comm_state == CS_INIT && power_state == PS_SWITCHED_ON
      |=> power_combo_illegal)
      else $error("switched on during init not flagged");
   chk_allow_only_op: assert property (
      power_op_enable_allowed |-> $past(comm_state) == CS_OP)
      else $error("enable allowed outside operational");
endmodule : fbsm_power_guard

// ---- fbsm_comm_state_machine.sv ----
// communication state machine of the drive's fieldbus slave
`timescale 1ns/10ps
module fbsm_comm_state_machine (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // state request from the control register write
   input wire logic req_valid,
   input wire logic [3:0] req_state,
   // state status and error flag
   output logic [3:0] status_state,
   output logic status_error,
   // traffic permissions
   output logic mailbox_enable,
   output logic pd_in_valid,
   output logic pd_out_apply,
   // power stage interlock
   input wire fbsm_pkg::fbsm_power_t power_state,
   output logic power_force_disable,
   output logic power_op_enable_allowed,
   output logic power_combo_illegal
);
   import fbsm_pkg::*;

   typedef struct packed {
      fbsm_comm_t comm;
      logic [3:0] status;
      logic err;
      logic mbx;
      logic pdin;
      logic pdout;
   } fbsm_state_t;

   fbsm_state_t st;
   fbsm_state_t next_st;
   fbsm_comm_t target;
   logic code_ok;
   logic move_up;
   logic move_ok;
   logic to_init;

   // decode the requested code; anything not one-hot is refused
   always_comb begin
      target = CS_INIT;
      code_ok = 1'b1;
      unique case (req_state)
         CODE_INIT: target = CS_INIT;
         CODE_PREOP: target = CS_PREOP;
         CODE_SAFEOP: target = CS_SAFEOP;
         CODE_OP: target = CS_OP;
         default: code_ok = 1'b0;
      endcase
   end

   // legality: up by exactly one, or any step down, or stay
   assign move_up = code_ok && (target > st.comm);
   assign move_ok = code_ok && (target <= st.comm
      || {1'b0, target} == {1'b0, st.comm} + 3'd1);
   assign to_init = req_valid && move_ok && target == CS_INIT
      && st.comm != CS_INIT;

   ////////////////////////////////////////////////////////////////////////////
   // next state; only a request moves the machine, never the power stage
   // a power fault therefore leaves the state as it is
   always_comb begin
      next_st = st;
      if (req_valid) begin
         if (move_ok) begin
            next_st.comm = target;
            next_st.err = 1'b0;
         end else begin
            // refused: old state kept, error stays until the next request
            next_st.err = 1'b1;
         end
      end
      next_st.status = fbsm_code(next_st.comm);
      // traffic permissions follow the state reached
      next_st.mbx = (next_st.comm != CS_INIT);
      next_st.pdin = (next_st.comm == CS_SAFEOP
         || next_st.comm == CS_OP);
      // outputs from the master are held off until operational
      next_st.pdout = (next_st.comm == CS_OP);
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st.comm <= CS_INIT;
         st.status <= STATUS_RESET;
         st.err <= ERROR_RESET;
         st.mbx <= 1'b0;
         st.pdin <= 1'b0;
         st.pdout <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign status_state = st.status;
   assign status_error = st.err;
   assign mailbox_enable = st.mbx;
   assign pd_in_valid = st.pdin;
   assign pd_out_apply = st.pdout;

   ////////////////////////////////////////////////////////////////////////////
   // power stage interlock; it sees the request in the cycle it is taken
   fbsm_power_guard u_guard (
      .core_clk(core_clk),
      .rst(rst),
      .cmd_taken(req_valid),
      .to_init(to_init),
      .comm_state(st.comm),
      .power_state(power_state),
      .power_force_disable(power_force_disable),
      .power_op_enable_allowed(power_op_enable_allowed),
      .power_combo_illegal(power_combo_illegal)
   );

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_skip_refused: assert property (
      req_valid && move_up && !move_ok
      |=> st.comm == $past(st.comm) && status_error)
      else $error("skipping upward request was carried out");
   chk_down_direct: assert property (
      req_valid && code_ok && target < st.comm
      |=> st.comm == $past(target) && !status_error)
      else $error("downward request not taken directly");
   chk_status_matches: assert property (
      req_valid && move_ok |=> status_state == fbsm_code($past(target)))
      else $error("status does not show the reached state");
   chk_bad_code_error: assert property (
      req_valid && !code_ok |=> status_error)
      else $error("illegal request code did not raise error");
   chk_error_holds: assert property (
      status_error && !req_valid |=> status_error && $stable(status_state))
      else $error("error or status changed without a request");
   chk_init_quiet: assert property (
      status_state == CODE_INIT |-> !mailbox_enable && !pd_in_valid
      && !pd_out_apply)
      else $error("traffic enabled in init");
   chk_preop_mbx: assert property (
      status_state == CODE_PREOP |-> mailbox_enable && !pd_in_valid
      && !pd_out_apply)
      else $error("preop traffic permissions wrong");
   chk_safeop_hold: assert property (
      status_state == CODE_SAFEOP |-> mailbox_enable && pd_in_valid
      && !pd_out_apply)
      else $error("safeop applies master outputs");
   chk_op_both: assert property (
      status_state == CODE_OP |-> mailbox_enable && pd_in_valid
      && pd_out_apply)
      else $error("op process data not valid both ways");
   chk_fault_keeps: assert property (
      power_state == PS_FAULT && !req_valid |=> $stable(st.comm))
      else $error("power fault changed communication state");

   cov_reach_op: cover property (
      req_valid && req_state == CODE_OP && move_ok);
   cov_skip: cover property (req_valid && move_up && !move_ok);
   cov_drop_init: cover property (to_init ##1 power_force_disable);
   cov_err_cleared: cover property (status_error ##1 !status_error);
endmodule : fbsm_comm_state_machine

// ---- fbsm_master_model.sv ----
// behavioural fieldbus master issuing state change requests
`timescale 1ns/10ps
module fbsm_master_model (
   // clock
   input wire logic core_clk,
   // state request towards the slave
   output logic req_valid,
   output logic [3:0] req_state
);
   // idle until the first request
   initial begin
      req_valid = 1'b0;
      req_state = 4'h0;
   end
   // one strobe per change; code line scrambled once released
   task automatic request(input logic [3:0] code);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_state <= code;
      @(posedge core_clk);
      req_valid <= 1'b0;
      req_state <= ~code;
   endtask : request
endmodule : fbsm_master_model

// ---- test_fieldbus_slave_state_machine.sv ----
// self-checking bench for the fieldbus slave state machine
`timescale 1ns/10ps
`define CHK(a, e) check(4'(a), 4'(e))
module test_fieldbus_slave_state_machine;
   import fbsm_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   fbsm_power_t power_state = PS_SWITCH_ON_DISABLED;
   logic req_valid;
   logic [3:0] req_state;
   logic [3:0] status_state;
   logic status_error;
   logic mailbox_enable;
   logic pd_in_valid;
   logic pd_out_apply;
   logic force_dis;
   logic op_allowed;
   logic illegal;
   int mismatches = 0;
   int total_checks = 0;
   ////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   always #20 core_clk = ~core_clk;
   // master model and slave under test
   fbsm_master_model u_fbsm_master_model (.core_clk(core_clk),
      .req_valid(req_valid), .req_state(req_state));
   fbsm_comm_state_machine u_fbsm_comm_state_machine (.core_clk(core_clk),
      .rst(rst), .req_valid(req_valid), .req_state(req_state),
      .status_state(status_state), .status_error(status_error),
      .mailbox_enable(mailbox_enable), .pd_in_valid(pd_in_valid),
      .pd_out_apply(pd_out_apply), .power_state(power_state),
      .power_force_disable(force_dis),
      .power_op_enable_allowed(op_allowed),
      .power_combo_illegal(illegal));
   ////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // verdict and end of run
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   // one request, then status and permissions one cycle later
   task automatic step(input logic [3:0] code, input logic [3:0] st,
         input logic err, input logic [2:0] perm);
      u_fbsm_master_model.request(code);
      #1;
      `CHK(status_state, st);
      `CHK(status_error, err);
      `CHK({mailbox_enable, pd_in_valid, pd_out_apply}, perm);
   endtask : step
   // settle a power state for two edges, lag of the flag included
   task automatic power_to(input fbsm_power_t p);
      @(posedge core_clk);
      power_state <= p;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : power_to
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      #1;
      `CHK(status_state, STATUS_RESET);
      `CHK(status_error, ERROR_RESET);
      `CHK({mailbox_enable, pd_in_valid, pd_out_apply}, 3'b000);
      `CHK({force_dis, op_allowed, illegal}, 3'b000);
      $display("test reset done");
   endtask : t_reset
   // bad code refused, same-state clears, power combos in init
   task automatic t_init;
      step(4'h3, CODE_INIT, 1'b1, 3'b000);
      step(CODE_INIT, CODE_INIT, 1'b0, 3'b000);
      power_to(PS_READY);
      `CHK(illegal, 1'b1);
      power_to(PS_NOT_READY);
      `CHK(illegal, 1'b0);
      step(CODE_PREOP, CODE_PREOP, 1'b0, 3'b100);
      power_to(PS_NOT_READY);
      `CHK(illegal, 1'b1);
      power_to(PS_SWITCH_ON_DISABLED);
      `CHK(illegal, 1'b0);
      $display("test init done");
   endtask : t_init
   // skip refused, then single steps up to operational
   task automatic t_upward;
      step(CODE_OP, CODE_PREOP, 1'b1, 3'b100);
      step(CODE_SAFEOP, CODE_SAFEOP, 1'b0, 3'b110);
      `CHK(op_allowed, 1'b0);
      step(CODE_OP, CODE_OP, 1'b0, 3'b111);
      @(posedge core_clk);
      #1;
      `CHK(op_allowed, 1'b1);
      power_to(PS_FAULT);
      `CHK(status_state, CODE_OP);
      `CHK(illegal, 1'b0);
      $display("test upward done");
   endtask : t_upward
   // direct drop to init while the power stage is enabled
   task automatic t_drop;
      power_to(PS_OP_ENABLED);
      `CHK(force_dis, 1'b0);
      step(CODE_INIT, CODE_INIT, 1'b0, 3'b000);
      `CHK(force_dis, 1'b1);
      @(posedge core_clk);
      #1;
      `CHK(force_dis, 1'b0);
      `CHK({op_allowed, illegal}, 2'b01);
      power_to(PS_SWITCH_ON_DISABLED);
      $display("test drop done");
   endtask : t_drop
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_init();
      t_upward();
      t_drop();
      finish_test();
   end
   // watchdog well beyond the 53 cycles the tests need; a long
   // margin so that a slow transition is never mistaken for a hang
   initial begin
      repeat (3000) @(posedge core_clk);
      mismatches++;
      finish_test();
   end
endmodule : test_fieldbus_slave_state_machine
